// File: pwm_channel_pkg.sv
// constants for one pulse-width-modulation channel register block
// assumes a plain strobe register port and a single mclk domain
// Behaviour
// - status bit 0 reads channel running
// - status bit 8 reports idle level
// - status bit 9 reports period start level
// - hold bit keeps last level on stop
// - status bit 11 reports interval mode
// - status bits 24-29 report stretch bits
// - mask register holds five source enables
// - raw status shows pending, ignores writes
// - masked status is pending and enable
// - clear register ones clear pending flags
// - first divider divides by two to N
// - second divider divides by M plus one
// - active divider register mirrors divider used
// - active period register shows period used
package pwm_channel_pkg;
  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] run_status_off     = 8'h14;
  localparam logic [7:0] interrupt_mask_off = 8'h18;
  localparam logic [7:0] raw_irq_off        = 8'h1C;
  localparam logic [7:0] masked_irq_off     = 8'h20;
  localparam logic [7:0] interrupt_clr_off  = 8'h24;
  localparam logic [7:0] clock_divider_off  = 8'h28;
  localparam logic [7:0] period_value_off   = 8'h2C;
  localparam logic [7:0] pulse_value_off    = 8'h30;
  localparam logic [7:0] active_div_off     = 8'h34;
  localparam logic [7:0] active_period_off  = 8'h38;
  localparam logic [7:0] active_pulse_off   = 8'h3C;
  localparam logic [7:0] channel_ctrl_off   = 8'h40;
  // ****************************************
  // field positions
  // ****************************************
  localparam int run_bit      = 0;
  localparam int idle_bit     = 8;
  localparam int start_bit    = 9;
  localparam int hold_bit     = 10;
  localparam int interval_bit = 11;
  localparam int stretch_lsb  = 24;
  localparam int div_n_lsb    = 0;
  localparam int div_m_lsb    = 4;
  // interrupt source positions
  localparam int ev_run_begin    = 0;
  localparam int ev_run_end      = 1;
  localparam int ev_period_begin = 2;
  localparam int ev_period_end   = 3;
  localparam int ev_pulse_match  = 4;
  localparam int num_events      = 5;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [31:0] reg_reset = 32'h0000_0000;
endpackage

// File: pwm_channel_status_irq_regs.sv
// one pwm channel: registers, two-stage divider, counter, interrupts
// assumes strobes from logic on mclk; output drives an external load
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
module pwm_channel_status_irq_regs (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic             pwm_out,
  output logic             irq
);
  import pwm_channel_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic        run;        // channel running
    logic        idle;       // idle output level
    logic        start_lvl;  // level at start of each period
    logic        hold;       // hold last level on stop
    logic        interval;   // one period then stop
    logic [5:0]  ex;         // cycle-stretch bits
    logic [4:0]  mask;       // interrupt enables
    logic [4:0]  raw;        // pending flags
    logic [3:0]  div_n;      // programmed power-of-two divider
    logic [10:0] div_m;      // programmed linear divider
    logic [15:0] period;     // programmed period
    logic [15:0] pulse;      // programmed pulse
    logic [3:0]  act_n;      // divider in force
    logic [10:0] act_m;
    logic [15:0] act_period; // period in force
    logic [15:0] act_pulse;  // pulse in force
    logic [15:0] pre_cnt;    // power-of-two stage
    logic [10:0] m_cnt;      // linear stage
    logic [15:0] cnt;        // period counter
    logic [5:0]  cyc;        // stretch cycle number
    logic        out;
    logic        irq;
    logic [31:0] rdata;
  } state_t;

  state_t s;       // registered state
  state_t next_s;  // next state
  logic [4:0] ev;  // events this cycle

  // ****************************************
  // helpers
  // ****************************************
  // terminal count of the power-of-two stage
  function automatic logic [15:0] pow2_last(input logic [3:0] n);
    pow2_last = 16'((17'h1 << n) - 17'h1);
  endfunction

  // cycle c gets one extra tick when the bit for its
  // lowest set position is on; cycle 0 is never stretched
  function automatic logic stretched(input logic [5:0] c,
                                     input logic [5:0] e);
    logic hit;
    logic found;
    hit = 1'b0;
    found = 1'b0;
    for (int i = 0; i < 6; i++) begin
      if (c[i] && !found) begin
        hit = e[5 - i];
        found = 1'b1;
      end
    end
    stretched = hit;
  endfunction

  // status word in shared layout of control and status
  function automatic logic [31:0] conf_word(input state_t v);
    logic [31:0] w;
    w = reg_reset;
    w[run_bit] = v.run;
    w[idle_bit] = v.idle;
    w[start_bit] = v.start_lvl;
    w[hold_bit] = v.hold;
    w[interval_bit] = v.interval;
    w[stretch_lsb +: 6] = v.ex;
    conf_word = w;
  endfunction

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    logic        pre_done;
    logic        tick;
    logic        last;
    logic [16:0] pulse_eff;
    logic        lvl;
    logic        stop;
    logic        go;
    next_s = s;
    ev = 5'h00;
    stop = 1'b0;
    go = 1'b0;
    next_s.rdata = reg_reset;
    pre_done = s.pre_cnt == pow2_last(s.act_n);
    tick = s.run && pre_done && (s.m_cnt == s.act_m);
    last = 17'(s.cnt) + 17'h1 >= 17'(s.act_period);
    pulse_eff = 17'(s.act_pulse) +
                17'(stretched(s.cyc, s.ex));
    lvl = (17'(s.cnt) < pulse_eff) ? s.start_lvl : !s.start_lvl;
    if (s.run) begin
      next_s.pre_cnt = pre_done ? 16'h0000 : 16'(s.pre_cnt + 16'h1);
      if (pre_done) begin
        next_s.m_cnt = (s.m_cnt == s.act_m) ? 11'h000
                                            : 11'(s.m_cnt + 11'h1);
      end
      next_s.out = lvl;
    end
    if (tick) begin
      if (s.cnt == 16'h0000) begin
        ev[ev_period_begin] = 1'b1;
      end
      if (s.cnt == s.act_pulse) begin
        ev[ev_pulse_match] = 1'b1;
      end
      if (last) begin
        // new divider, period and pulse settings take effect at the period boundary so a
        // period never mixes their old and new values
        ev[ev_period_end] = 1'b1;
        next_s.cnt = 16'h0000;
        next_s.cyc = 6'(s.cyc + 6'h1);
        next_s.act_n = s.div_n;
        next_s.act_m = s.div_m;
        next_s.act_period = s.period;
        next_s.act_pulse = s.pulse;
        stop = s.interval;
      end else begin
        next_s.cnt = 16'(s.cnt + 16'h1);
      end
    end
    // ---------- register writes ----------
    if (wr) begin
      if (addr == interrupt_mask_off) begin
        next_s.mask = wdata[num_events-1:0];
      end else if (addr == clock_divider_off) begin
        next_s.div_n = wdata[div_n_lsb +: 4];
        next_s.div_m = wdata[div_m_lsb +: 11];
      end else if (addr == period_value_off) begin
        next_s.period = wdata[15:0];
      end else if (addr == pulse_value_off) begin
        next_s.pulse = wdata[15:0];
      end else if (addr == channel_ctrl_off) begin
        next_s.idle = wdata[idle_bit];
        next_s.start_lvl = wdata[start_bit];
        next_s.hold = wdata[hold_bit];
        next_s.interval = wdata[interval_bit];
        next_s.ex = wdata[stretch_lsb +: 6];
        go = wdata[run_bit] && !s.run;
        stop = stop || (!wdata[run_bit] && s.run);
      end
      // raw and masked status ignore writes
      // no write path to pending flags there
    end
    // ---------- start and stop ----------
    if (go) begin
      ev[ev_run_begin] = 1'b1;
      next_s.run = 1'b1;
      next_s.pre_cnt = 16'h0000;
      next_s.m_cnt = 11'h000;
      next_s.cnt = 16'h0000;
      next_s.cyc = 6'h00;
      next_s.act_n = s.div_n;
      next_s.act_m = s.div_m;
      next_s.act_period = s.period;
      next_s.act_pulse = s.pulse;
    end else if (stop && s.run) begin
      ev[ev_run_end] = 1'b1;
      next_s.run = 1'b0;
      // hold keeps the final level
      // a stop may carry new hold and idle bits in the same write,
      // so the written values decide, not the ones being replaced
      next_s.out = next_s.hold ? s.out : next_s.idle;
    end else if (!s.run && !next_s.hold) begin
      next_s.out = next_s.idle;
    end
    // ---------- pending flags ----------
    // a one clears; a new event wins over it
    if (wr && addr == interrupt_clr_off) begin
      next_s.raw = s.raw & ~wdata[num_events-1:0];
    end
    next_s.raw = next_s.raw | ev;
    next_s.irq = |(next_s.raw & next_s.mask);
    // ---------- register reads ----------
    if (rd) begin
      if (addr == run_status_off) begin
        next_s.rdata = conf_word(s);
      end else if (addr == channel_ctrl_off) begin
        next_s.rdata = conf_word(s);
      end else if (addr == interrupt_mask_off) begin
        next_s.rdata = 32'(s.mask);
      end else if (addr == raw_irq_off) begin
        next_s.rdata = 32'(s.raw);
      end else if (addr == masked_irq_off) begin
        next_s.rdata = 32'(s.raw & s.mask);
      end else if (addr == clock_divider_off) begin
        next_s.rdata = 32'({s.div_m, s.div_n});
      end else if (addr == period_value_off) begin
        next_s.rdata = 32'(s.period);
      end else if (addr == pulse_value_off) begin
        next_s.rdata = 32'(s.pulse);
      end else if (addr == active_div_off) begin
        next_s.rdata = 32'({s.act_m, s.act_n});
      end else if (addr == active_period_off) begin
        next_s.rdata = 32'(s.act_period);
      end else if (addr == active_pulse_off) begin
        next_s.rdata = 32'(s.act_pulse);
      end else begin
        // unmapped offsets read zero
        next_s.rdata = reg_reset;
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign pwm_out = s.out;
  assign irq = s.irq;

  // ****************************************
  // checks
  // ****************************************
  property p_run_read;
    @(posedge mclk) disable iff (!reset_n)
    rd && addr == run_status_off |=> rdata[run_bit] == $past(s.run);
  endproperty
  a_run_read: assert property (p_run_read)
    else $error("status run bit wrong");

  property p_idle_read;
    @(posedge mclk) disable iff (!reset_n)
    rd && addr == run_status_off |=> rdata[idle_bit] == $past(s.idle);
  endproperty
  a_idle_read: assert property (p_idle_read)
    else $error("status idle bit wrong");

  property p_start_read;
    @(posedge mclk) disable iff (!reset_n)
    rd && addr == run_status_off
      |=> rdata[start_bit] == $past(s.start_lvl);
  endproperty
  a_start_read: assert property (p_start_read)
    else $error("status start level bit wrong");

  property p_hold_stop;
    @(posedge mclk) disable iff (!reset_n)
    s.run && !next_s.run && next_s.hold |=> pwm_out == $past(pwm_out);
  endproperty
  a_hold_stop: assert property (p_hold_stop)
    else $error("output not held on stop");

  property p_idle_stop;
    @(posedge mclk) disable iff (!reset_n)
    s.run && !next_s.run && !next_s.hold
      |=> pwm_out == $past(next_s.idle);
  endproperty
  a_idle_stop: assert property (p_idle_stop)
    else $error("output not at idle level after stop");

  property p_mask_write;
    @(posedge mclk) disable iff (!reset_n)
    wr && addr == interrupt_mask_off
      |=> s.mask == $past(wdata[num_events-1:0]);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask write lost");

  property p_masked_read;
    @(posedge mclk) disable iff (!reset_n)
    rd && addr == masked_irq_off
      |=> rdata[4:0] == $past(s.raw & s.mask);
  endproperty
  a_masked_read: assert property (p_masked_read)
    else $error("masked status wrong");

  property p_clear;
    @(posedge mclk) disable iff (!reset_n)
    wr && addr == interrupt_clr_off && wdata[0] && !ev[0]
      |=> !s.raw[0];
  endproperty
  a_clear: assert property (p_clear)
    else $error("pending flag not cleared");

  property p_sticky;
    @(posedge mclk) disable iff (!reset_n)
    s.raw[ev_period_end] && !(wr && addr == interrupt_clr_off)
      |=> s.raw[ev_period_end];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("pending flag dropped");

  property p_active_div;
    @(posedge mclk) disable iff (!reset_n)
    rd && addr == active_div_off
      |=> rdata[14:0] == $past({s.act_m, s.act_n});
  endproperty
  a_active_div: assert property (p_active_div)
    else $error("active divider read wrong");

  property p_irq_out;
    @(posedge mclk) disable iff (!reset_n)
    ##1 irq == |($past(next_s.raw & next_s.mask));
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("interrupt output wrong");

  property p_mask_read;
    @(posedge mclk) disable iff (!reset_n)
    rd && addr == interrupt_mask_off
      |=> rdata[num_events-1:0] == $past(s.mask);
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("mask read wrong");

  property p_raw_read;
    @(posedge mclk) disable iff (!reset_n)
    rd && addr == raw_irq_off
      |=> rdata[num_events-1:0] == $past(s.raw);
  endproperty
  a_raw_read: assert property (p_raw_read)
    else $error("raw status read wrong");

  property p_raw_no_write;
    @(posedge mclk) disable iff (!reset_n)
    wr && (addr == raw_irq_off || addr == masked_irq_off)
      |=> s.raw == ($past(s.raw) | $past(ev));
  endproperty
  a_raw_no_write: assert property (p_raw_no_write)
    else $error("status write changed pending flags");

  property p_interval_read;
    @(posedge mclk) disable iff (!reset_n)
    rd && addr == run_status_off
      |=> rdata[interval_bit] == $past(s.interval);
  endproperty
  a_interval_read: assert property (p_interval_read)
    else $error("status interval bit wrong");

  property p_stretch_read;
    @(posedge mclk) disable iff (!reset_n)
    rd && addr == run_status_off
      |=> rdata[stretch_lsb +: 6] == $past(s.ex);
  endproperty
  a_stretch_read: assert property (p_stretch_read)
    else $error("status stretch bits wrong");

  property p_period_read;
    @(posedge mclk) disable iff (!reset_n)
    rd && addr == active_period_off
      |=> rdata[15:0] == $past(s.act_period);
  endproperty
  a_period_read: assert property (p_period_read)
    else $error("active period read wrong");
endmodule

// File: pwm_load_model.sv
// load on the pwm pin: measures high time and period length in clocks
// assumes the pin is a registered level that changes only after mclk
`timescale 1ns/10ps
module pwm_load_model (
  input  wire logic mclk,
  input  wire logic pwm_out,
  output int        hi_len,
  output int        per_len
);
  logic prev; // pin level at the previous edge
  int   cnt;  // clocks since the last rising edge
  int   hc;   // high clocks since the last rising edge
  // ****************************************
  // measurement
  // ****************************************
  // a purely resistive load: it never disturbs the pin, it only times it;
  // one process owns every variable so none of them has two drivers
  initial begin
    prev    = 1'b0;
    cnt     = 0;
    hc      = 0;
    hi_len  = 0;
    per_len = 0;
    forever begin
      @(posedge mclk);
      prev <= pwm_out;
      cnt  <= cnt + 1;
      hc   <= hc + int'(pwm_out);
      if (pwm_out && !prev) begin
        per_len <= cnt;
        hi_len  <= hc;
        cnt     <= 1;
        hc      <= 1;
      end
    end
  end
endmodule

// File: tb_pwm_channel_status_irq_regs.sv
// self-checking bench for one pwm channel register block
// assumes the register map and control layout of pwm_channel_pkg
`timescale 1ns/10ps
module tb_pwm_channel_status_irq_regs;
  import pwm_channel_pkg::*;
  logic        mclk, reset_n, wr, rd, rd_d, pwm_out, irq, lvl;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, ctl, div;
  logic [4:0]  m;
  int          hi_len, per_len, n, mm, t, fail_count, total_checks;
  logic [31:0] exp_q[$]; // expected read data, oldest first
  pwm_channel_status_irq_regs dut_u (.mclk(mclk), .reset_n(reset_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .pwm_out(pwm_out), .irq(irq));
  pwm_load_model load_u (.mclk(mclk), .pwm_out(pwm_out),
    .hi_len(hi_len), .per_len(per_len));
  // ****************************************
  // clock, compare, bus tasks
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one-cycle write strobe; a gap cycle follows so strobes never merge
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // read strobe; the expectation waits in the queue for the monitor
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk);
    rd <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe: look mid-cycle
  always @(posedge mclk) rd_d <= rd;
  always @(negedge mclk) if (rd_d === 1'b1) check(rdata, exp_q.pop_front());
  // ****************************************
  // watchdog
  // ****************************************
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    summarize();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {wr, rd, addr, wdata, fail_count, total_checks} = '0;
    reset_n = 1'b0;
    void'($urandom(32'h44EE080E));
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    // every register from run status to active period comes out of reset as zero
    for (int a = 8'h14; a <= 8'h38; a += 4) rd_chk(8'(a), 32'h0);
    m = 5'($urandom);
    wr_reg(interrupt_mask_off, {27'h7FFFFFF, m});
    rd_chk(interrupt_mask_off, {27'h0, m});
    n  = 1 + int'($urandom % 2);
    mm = int'($urandom % 3);
    t  = (1 << n) * (mm + 1); // clocks per counter step
    div = 32'((mm << 4) | n);
    wr_reg(clock_divider_off, div);
    rd_chk(clock_divider_off, div);
    // software keeps period nonzero and above a nonzero pulse
    wr_reg(period_value_off, 32'h5);
    wr_reg(pulse_value_off, 32'h2);
    wr_reg(channel_ctrl_off, 32'h201);
    wr_reg(period_value_off, 32'h6);
    rd_chk(active_period_off, 32'h5);
    rd_chk(run_status_off, 32'h201);
    rd_chk(active_div_off, div);
    repeat (20 * t) @(negedge mclk);
    check(32'(per_len), 32'(6 * t));
    check(32'(hi_len), 32'(2 * t));
    rd_chk(active_period_off, 32'h6);
    // run began, period began, period ended and pulse match all pending
    rd_chk(raw_irq_off, 32'h1D);
    wr_reg(raw_irq_off, 32'h0);
    rd_chk(raw_irq_off, 32'h1D);
    wr_reg(masked_irq_off, 32'h0);
    rd_chk(masked_irq_off, {27'h0, m & 5'h1D});
    @(negedge mclk);
    check({31'h0, irq}, {31'h0, |(m & 5'h1D)});
    wr_reg(interrupt_mask_off, 32'h1);
    wr_reg(interrupt_clr_off, 32'h1);
    rd_chk(raw_irq_off, 32'h1C);
    rd_chk(interrupt_clr_off, 32'h0);
    rd_chk(8'h7C, 32'h0);
    @(negedge mclk);
    check({31'h0, irq}, 32'h0);
    // stop with hold: the pin must freeze at the level it had in the
    // cycle the stop is taken, although idle is written high with it
    @(posedge mclk);
    addr  <= channel_ctrl_off;
    wdata <= 32'h500;
    wr    <= 1'b1;
    @(negedge mclk);
    lvl = pwm_out;
    @(posedge mclk);
    wr <= 1'b0;
    repeat (12 * t) @(negedge mclk);
    check({31'h0, pwm_out}, {31'h0, lvl});
    wr_reg(interrupt_mask_off, 32'h2);
    @(negedge mclk);
    check({31'h0, irq}, 32'h1);
    // stopped, hold cleared: pin follows the idle level
    wr_reg(channel_ctrl_off, 32'h100);
    repeat (3) @(negedge mclk);
    check({31'h0, pwm_out}, 32'h1);
    rd_chk(run_status_off, 32'h100);
    wr_reg(channel_ctrl_off, 32'h0);
    repeat (3) @(negedge mclk);
    check({31'h0, pwm_out}, 32'h0);
    // interval mode runs one period then halts by itself
    ctl = {2'b00, 6'($urandom), 12'h0, 12'hA00};
    wr_reg(channel_ctrl_off, ctl);
    rd_chk(run_status_off, ctl);
    wr_reg(channel_ctrl_off, ctl | 32'h1);
    rd_chk(run_status_off, ctl | 32'h1);
    repeat (8 * t + 10) @(posedge mclk);
    rd_chk(run_status_off, ctl);
    repeat (3) @(posedge mclk);
    summarize();
  end
endmodule
